// ==== hw/typec_phy_attach_select_pkg.sv ====
// Constants, field positions and reset values for the Type-C PHY attach selector
package typec_phy_attach_select_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int NUM_PORTS = 3;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int SYNC_W = 14;

    // ------------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] REG_CTRL_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] REG_STATUS_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] REG_INPUTS_OFS = 8'h08;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CTRL_MASK_LSB = 0;
    localparam int STS_PHYA_LSB = 0;
    localparam int STS_PHYB_LSB = 3;
    localparam int STS_MODE_BIT = 6;
    localparam int STS_POL_BIT = 7;
    localparam int STS_PWR_LSB = 8;
    localparam int IN_ATTACH_LSB = 0;
    localparam int IN_ORIENT_LSB = 3;
    localparam int IN_SIDEA_LSB = 6;
    localparam int IN_SIDEB_LSB = 9;
    localparam int IN_POL_BIT = 12;
    localparam int IN_MODE_BIT = 13;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [NUM_PORTS-1:0] CTRL_MASK_RST = 3'h7;
    localparam logic [NUM_PORTS-1:0] PHY_EN_RST = 3'h0;
    localparam logic [SYNC_W-1:0] SYNC_RST = 14'h0000;
    localparam logic [DATA_W-1:0] RD_DATA_RST = 32'h0000_0000;

endpackage

// ==== hw/pin_input_sync.sv ====
// Three-stage pin synchroniser with agreement filter
module pin_input_sync
    import typec_phy_attach_select_pkg::*;
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [SYNC_W-1:0] pinIn,
    output logic [SYNC_W-1:0] levelOut
);

    logic [SYNC_W-1:0] stage1_q;
    logic [SYNC_W-1:0] stage2_q;
    logic [SYNC_W-1:0] stage3_q;
    logic [SYNC_W-1:0] level_q;
    logic [SYNC_W-1:0] level_d;

    // ------------------------------------------------------------------
    // Filter: a bit moves only once stages two and three agree
    // ------------------------------------------------------------------
    always_comb
    begin
        level_d = level_q;
        for (int b = 0; b < SYNC_W; b++)
        begin
            if (stage2_q[b] == stage3_q[b])
            begin
                level_d[b] = stage3_q[b];
            end
        end
    end

    // Stage one feeds stage two only, so metastability never reaches logic
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            stage1_q <= SYNC_RST;
            stage2_q <= SYNC_RST;
            stage3_q <= SYNC_RST;
            level_q <= SYNC_RST;
        end
        else
        begin
            stage1_q <= pinIn;
            stage2_q <= stage1_q;
            stage3_q <= stage2_q;
            level_q <= level_d;
        end
    end

    assign levelOut = level_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_sync_follow;
        @(posedge ref_clk) disable iff (!nrst)
        1'b1 |=> (((level_q ^ $past(stage3_q)) & ~$past(stage2_q ^ stage3_q)) == SYNC_RST);
    endproperty
    a_sync_follow: assert property (p_sync_follow) else $error("Filter missed agreed level");

    property p_sync_hold;
        @(posedge ref_clk) disable iff (!nrst)
        1'b1 |=> (((level_q ^ $past(level_q)) & $past(stage2_q ^ stage3_q)) == SYNC_RST);
    endproperty
    a_sync_hold: assert property (p_sync_hold) else $error("Filter moved on disagreement");

endmodule // pin_input_sync

// ==== hw/typec_phy_attach_select.sv ====
// Type-C attach and orientation decode driving per-port PHY enables
module typec_phy_attach_select
    import typec_phy_attach_select_pkg::*;
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [NUM_PORTS-1:0] portAttachIn,
    input wire logic [NUM_PORTS-1:0] portOrientationIn,
    input wire logic [NUM_PORTS-1:0] orientAAttachIn,
    input wire logic [NUM_PORTS-1:0] orientBAttachIn,
    input wire logic attachPolaritySel,
    input wire logic controlModeTwoSel,
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWrData,
    input wire logic regWrStrobe,
    input wire logic regRdStrobe,
    output logic [DATA_W-1:0] regRdData,
    output logic [NUM_PORTS-1:0] phyEnA,
    output logic [NUM_PORTS-1:0] phyEnB,
    output logic [NUM_PORTS-1:0] phyPwrEn
);

    // ------------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------------
    logic [SYNC_W-1:0] rawPins;
    logic [SYNC_W-1:0] syncPins;
    logic [NUM_PORTS-1:0] attachLvl;
    logic [NUM_PORTS-1:0] orientLvl;
    logic [NUM_PORTS-1:0] sideALvl;
    logic [NUM_PORTS-1:0] sideBLvl;
    logic polLvl;
    logic modeTwo;

    // All pins travel together through one synchroniser bank
    assign rawPins = {controlModeTwoSel, attachPolaritySel, orientBAttachIn,
                      orientAAttachIn, portOrientationIn, portAttachIn};

    pin_input_sync u_sync (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .pinIn(rawPins),
        .levelOut(syncPins)
    );

    // Field split of the synchronised levels
    assign attachLvl = syncPins[IN_ATTACH_LSB +: NUM_PORTS];
    assign orientLvl = syncPins[IN_ORIENT_LSB +: NUM_PORTS];
    assign sideALvl = syncPins[IN_SIDEA_LSB +: NUM_PORTS];
    assign sideBLvl = syncPins[IN_SIDEB_LSB +: NUM_PORTS];
    assign polLvl = syncPins[IN_POL_BIT];
    assign modeTwo = syncPins[IN_MODE_BIT];

    // ------------------------------------------------------------------
    // Per-port decode
    // ------------------------------------------------------------------
    logic [NUM_PORTS-1:0] wantA;
    logic [NUM_PORTS-1:0] wantB;
    logic [NUM_PORTS-1:0] portMask_q;

    // Polarity is a plain XOR so one decode serves both strap settings
    for (genvar p = 0; p < NUM_PORTS; p++)
    begin : g_port
        logic attached;
        logic sideIsB;
        logic sideAOn;
        logic sideBOn;
        assign attached = attachLvl[p] ^ polLvl;
        assign sideIsB = orientLvl[p] ^ polLvl;
        assign sideAOn = sideALvl[p] ^ polLvl;
        assign sideBOn = sideBLvl[p] ^ polLvl;
        // Mode one uses only this port's attach and orientation levels
        assign wantA[p] = portMask_q[p] &
                          (modeTwo ? sideAOn : (attached & ~sideIsB));
        assign wantB[p] = portMask_q[p] &
                          (modeTwo ? sideBOn : (attached & sideIsB));
    end

    // ------------------------------------------------------------------
    // PHY enable registers
    // ------------------------------------------------------------------
    logic [NUM_PORTS-1:0] phyEnA_q;
    logic [NUM_PORTS-1:0] phyEnA_d;
    logic [NUM_PORTS-1:0] phyEnB_q;
    logic [NUM_PORTS-1:0] phyEnB_d;
    logic [NUM_PORTS-1:0] phyPwr_q;
    logic [NUM_PORTS-1:0] phyPwr_d;

    // Pair power follows either side so an idle port draws no PHY current
    always_comb
    begin
        phyEnA_d = wantA;
        phyEnB_d = wantB;
        phyPwr_d = wantA | wantB;
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            phyEnA_q <= PHY_EN_RST;
            phyEnB_q <= PHY_EN_RST;
            phyPwr_q <= PHY_EN_RST;
        end
        else
        begin
            phyEnA_q <= phyEnA_d;
            phyEnB_q <= phyEnB_d;
            phyPwr_q <= phyPwr_d;
        end
    end

    assign phyEnA = phyEnA_q;
    assign phyEnB = phyEnB_q;
    assign phyPwrEn = phyPwr_q;

    // ------------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------------
    logic [NUM_PORTS-1:0] portMask_d;
    logic [DATA_W-1:0] rdData_q;
    logic [DATA_W-1:0] rdData_d;

    // Control write and read mux; unmapped reads return zero
    always_comb
    begin
        portMask_d = portMask_q;
        rdData_d = RD_DATA_RST;
        if (regWrStrobe && (regAddr == REG_CTRL_OFS))
        begin
            portMask_d = regWrData[CTRL_MASK_LSB +: NUM_PORTS];
        end
        if (regRdStrobe)
        begin
            case (regAddr)
                REG_CTRL_OFS:
                begin
                    rdData_d[CTRL_MASK_LSB +: NUM_PORTS] = portMask_q;
                end
                REG_STATUS_OFS:
                begin
                    rdData_d[STS_PHYA_LSB +: NUM_PORTS] = phyEnA_q;
                    rdData_d[STS_PHYB_LSB +: NUM_PORTS] = phyEnB_q;
                    rdData_d[STS_MODE_BIT] = modeTwo;
                    rdData_d[STS_POL_BIT] = polLvl;
                    rdData_d[STS_PWR_LSB +: NUM_PORTS] = phyPwr_q;
                end
                REG_INPUTS_OFS:
                begin
                    rdData_d[SYNC_W-1:0] = syncPins;
                end
                default:
                begin
                    rdData_d = RD_DATA_RST;
                end
            endcase
        end
    end

    // Read data stand for exactly the cycle after the strobe
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            portMask_q <= CTRL_MASK_RST;
            rdData_q <= RD_DATA_RST;
        end
        else
        begin
            portMask_q <= portMask_d;
            rdData_q <= rdData_d;
        end
    end

    assign regRdData = rdData_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_mode1_power;
        @(posedge ref_clk) disable iff (!nrst)
        !modeTwo |=> (phyPwr_q == $past((attachLvl ^ {NUM_PORTS{polLvl}}) & portMask_q));
    endproperty
    a_mode1_power: assert property (p_mode1_power) else $error("Mode one power mismatch");

    property p_pol_low_attach;
        @(posedge ref_clk) disable iff (!nrst)
        (!modeTwo && !polLvl) |=> (phyPwr_q == $past(attachLvl & portMask_q));
    endproperty
    a_pol_low_attach: assert property (p_pol_low_attach) else $error("Active-high attach wrong");

    property p_pol_high_attach;
        @(posedge ref_clk) disable iff (!nrst)
        (!modeTwo && polLvl) |=> (phyPwr_q == $past(~attachLvl & portMask_q));
    endproperty
    a_pol_high_attach: assert property (p_pol_high_attach) else $error("Active-low attach wrong");

    property p_pol_low_orient;
        @(posedge ref_clk) disable iff (!nrst)
        (!modeTwo && !polLvl) |=> (phyEnB_q == $past(attachLvl & orientLvl & portMask_q))
            && (phyEnA_q == $past(attachLvl & ~orientLvl & portMask_q));
    endproperty
    a_pol_low_orient: assert property (p_pol_low_orient) else $error("Orientation low pol wrong");

    property p_pol_high_orient;
        @(posedge ref_clk) disable iff (!nrst)
        (!modeTwo && polLvl) |=> (phyEnA_q == $past(~attachLvl & orientLvl & portMask_q))
            && (phyEnB_q == $past(~attachLvl & ~orientLvl & portMask_q));
    endproperty
    a_pol_high_orient: assert property (p_pol_high_orient) else $error("Orientation high pol wrong");

    property p_mode1_one_side;
        @(posedge ref_clk) disable iff (!nrst)
        !modeTwo |=> ((phyEnA_q & phyEnB_q) == PHY_EN_RST) && ((phyEnA_q | phyEnB_q) == phyPwr_q);
    endproperty
    a_mode1_one_side: assert property (p_mode1_one_side) else $error("Both sides on in mode one");

    property p_mode2_side_b;
        @(posedge ref_clk) disable iff (!nrst)
        modeTwo |=> (phyEnB_q == $past((sideBLvl ^ {NUM_PORTS{polLvl}}) & portMask_q));
    endproperty
    a_mode2_side_b: assert property (p_mode2_side_b) else $error("Mode two side B wrong");

    property p_mode2_side_a;
        @(posedge ref_clk) disable iff (!nrst)
        (modeTwo && !polLvl) |=> (phyEnA_q == $past(sideALvl & portMask_q));
    endproperty
    a_mode2_side_a: assert property (p_mode2_side_a) else $error("Mode two side A wrong");

    property p_mode2_pol_high;
        @(posedge ref_clk) disable iff (!nrst)
        (modeTwo && polLvl) |=> (phyEnA_q == $past(~sideALvl & portMask_q));
    endproperty
    a_mode2_pol_high: assert property (p_mode2_pol_high) else $error("Side A polarity wrong");

    property p_mode1_ignores_side;
        @(posedge ref_clk) disable iff (!nrst)
        (!modeTwo && $stable(attachLvl) && $stable(orientLvl) && $stable(polLvl)
            && $stable(portMask_q) && $past(!modeTwo))
            |=> $stable(phyEnA_q) && $stable(phyEnB_q);
    endproperty
    a_mode1_ignores_side: assert property (p_mode1_ignores_side) else $error("Side pins leaked");

    property p_read_one_cycle;
        @(posedge ref_clk) disable iff (!nrst)
        !regRdStrobe |=> (rdData_q == RD_DATA_RST);
    endproperty
    a_read_one_cycle: assert property (p_read_one_cycle) else $error("Read data stood too long");

    // Pair power must never disagree with the side enables, even in mode two
    property p_pair_power;
        @(posedge ref_clk) disable iff (!nrst)
        1'b1 |-> (phyPwr_q == (phyEnA_q | phyEnB_q));
    endproperty
    a_pair_power: assert property (p_pair_power) else $error("Pair power not side union");

    property p_masked_off;
        @(posedge ref_clk) disable iff (!nrst)
        1'b1 |=> ((phyPwr_q & ~$past(portMask_q)) == PHY_EN_RST);
    endproperty
    a_masked_off: assert property (p_masked_off) else $error("Masked port powered");

    property p_mask_write;
        @(posedge ref_clk) disable iff (!nrst)
        (regWrStrobe && (regAddr == REG_CTRL_OFS))
            |=> (portMask_q == $past(regWrData[CTRL_MASK_LSB +: NUM_PORTS]));
    endproperty
    a_mask_write: assert property (p_mask_write) else $error("Mask write lost");

    property p_status_read;
        @(posedge ref_clk) disable iff (!nrst)
        (regRdStrobe && (regAddr == REG_STATUS_OFS))
            |=> (rdData_q[STS_PWR_LSB +: NUM_PORTS] == $past(phyPwr_q));
    endproperty
    a_status_read: assert property (p_status_read) else $error("Status power field wrong");

    property p_inputs_read;
        @(posedge ref_clk) disable iff (!nrst)
        (regRdStrobe && (regAddr == REG_INPUTS_OFS))
            |=> (rdData_q[SYNC_W-1:0] == $past(syncPins));
    endproperty
    a_inputs_read: assert property (p_inputs_read) else $error("Input levels read wrong");

    property p_unmapped_read;
        @(posedge ref_clk) disable iff (!nrst)
        (regRdStrobe && (regAddr != REG_CTRL_OFS) && (regAddr != REG_STATUS_OFS)
            && (regAddr != REG_INPUTS_OFS)) |=> (rdData_q == RD_DATA_RST);
    endproperty
    a_unmapped_read: assert property (p_unmapped_read) else $error("Unmapped read not zero");

    property p_mode2_ignores_pins;
        @(posedge ref_clk) disable iff (!nrst)
        (modeTwo && $stable(sideALvl) && $stable(sideBLvl) && $stable(polLvl)
            && $stable(portMask_q) && $past(modeTwo))
            |=> $stable(phyEnA_q) && $stable(phyEnB_q);
    endproperty
    a_mode2_ignores_pins: assert property (p_mode2_ignores_pins) else $error("Mode one pins leaked");

    // Main scenarios
    c_mode1_side_a: cover property (@(posedge ref_clk) disable iff (!nrst)
        !modeTwo && !polLvl && (phyEnA_q != PHY_EN_RST));
    c_mode1_side_b: cover property (@(posedge ref_clk) disable iff (!nrst)
        !modeTwo && polLvl && (phyEnB_q != PHY_EN_RST));
    c_mode2_both: cover property (@(posedge ref_clk) disable iff (!nrst)
        modeTwo && ((phyEnA_q & phyEnB_q) != PHY_EN_RST));
    c_mask_write: cover property (@(posedge ref_clk) disable iff (!nrst)
        regWrStrobe && (regAddr == REG_CTRL_OFS) ##1 (portMask_q != CTRL_MASK_RST));
    c_all_ports_on: cover property (@(posedge ref_clk) disable iff (!nrst)
        !modeTwo && (phyPwr_q == {NUM_PORTS{1'b1}}));

endmodule // typec_phy_attach_select

// ==== dv/typec_detector_model.sv ====
// Behavioural model of the external Type-C attach and orientation detector
module typec_detector_model
    import typec_phy_attach_select_pkg::*;
(
    input wire logic ref_clk,
    input wire logic [NUM_PORTS-1:0] connected,
    input wire logic [NUM_PORTS-1:0] flipped,
    input wire logic polSel,
    input wire logic modeTwo,
    input wire logic legacy,
    output logic [NUM_PORTS-1:0] portAttachIn,
    output logic [NUM_PORTS-1:0] portOrientationIn,
    output logic [NUM_PORTS-1:0] orientAAttachIn,
    output logic [NUM_PORTS-1:0] orientBAttachIn,
    output logic attachPolaritySel,
    output logic controlModeTwoSel
);
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------------------------------
    // Pin drive
    // ----------------------------------------------------------------
    logic [2:0] wanderCnt = 3'h0;
    logic [NUM_PORTS-1:0] wander;
    logic [NUM_PORTS-1:0] polMask;

    // Unused pins keep moving slowly so that the filter passes them on
    assign wander = {NUM_PORTS{wanderCnt[2]}};
    assign polMask = {NUM_PORTS{polSel}};

    // Pins start idle so the block sees no attach at release of reset
    initial
    begin
        portAttachIn = 3'h0;
        portOrientationIn = 3'h0;
        orientAAttachIn = 3'h0;
        orientBAttachIn = 3'h0;
        attachPolaritySel = 1'b0;
        controlModeTwoSel = 1'b0;
    end

    // Levels change just after an edge, encoded by the chosen polarity except on a legacy board
    always @(posedge ref_clk)
    begin
        wanderCnt <= wanderCnt + 3'h1;
        attachPolaritySel <= polSel;
        controlModeTwoSel <= modeTwo;
        if (legacy)
        begin
            portAttachIn <= 3'h7;
            portOrientationIn <= flipped;
            orientAAttachIn <= wander;
            orientBAttachIn <= ~wander;
        end
        else if (!modeTwo)
        begin
            portAttachIn <= connected ^ polMask;
            portOrientationIn <= flipped ^ polMask;
            orientAAttachIn <= wander;
            orientBAttachIn <= ~wander;
        end
        else
        begin
            portAttachIn <= wander;
            portOrientationIn <= ~wander;
            orientAAttachIn <= (connected & ~flipped) ^ polMask;
            orientBAttachIn <= (connected & flipped) ^ polMask;
        end
    end
endmodule // typec_detector_model

// ==== dv/tb.sv ====
// Self-checking bench for the Type-C PHY attach selector
module tb
    import typec_phy_attach_select_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------------------------------
    // Stimulus and wiring
    // ----------------------------------------------------------------
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic [NUM_PORTS-1:0] connected = 3'h0;
    logic [NUM_PORTS-1:0] flipped = 3'h0;
    logic polSel = 1'b0;
    logic modeTwo = 1'b0;
    logic legacy = 1'b0;
    logic [ADDR_W-1:0] regAddr = 8'h00;
    logic [DATA_W-1:0] regWrData = 32'h0000_0000;
    logic regWrStrobe = 1'b0;
    logic regRdStrobe = 1'b0;
    logic [NUM_PORTS-1:0] maskExp = 3'h7;
    logic [NUM_PORTS-1:0] attIn, oriIn, sideA, sideB, phyEnA, phyEnB, phyPwrEn;
    logic polPin, modePin;
    logic [DATA_W-1:0] regRdData;
    int error_cnt = 0;
    int checked = 0;

    // 25 MHz core clock
    always #20 ref_clk = ~ref_clk;

    typec_detector_model typec_detector_model_inst (.ref_clk(ref_clk), .connected(connected),
        .flipped(flipped), .polSel(polSel), .modeTwo(modeTwo), .legacy(legacy),
        .portAttachIn(attIn), .portOrientationIn(oriIn), .orientAAttachIn(sideA),
        .orientBAttachIn(sideB), .attachPolaritySel(polPin), .controlModeTwoSel(modePin));

    typec_phy_attach_select typec_phy_attach_select_inst (.ref_clk(ref_clk), .nrst(nrst),
        .portAttachIn(attIn), .portOrientationIn(oriIn), .orientAAttachIn(sideA),
        .orientBAttachIn(sideB), .attachPolaritySel(polPin), .controlModeTwoSel(modePin),
        .regAddr(regAddr), .regWrData(regWrData), .regWrStrobe(regWrStrobe),
        .regRdStrobe(regRdStrobe), .regRdData(regRdData), .phyEnA(phyEnA),
        .phyEnB(phyEnB), .phyPwrEn(phyPwrEn));

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    // Verdict in one place, also reached by the watchdog
    task automatic test_done();
        if (error_cnt == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic check_word(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_vec(input logic [NUM_PORTS-1:0] got, input logic [NUM_PORTS-1:0] exp);
        checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Bus tasks start and end just after a rising edge, so a read may follow a write
    task automatic reg_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        regAddr <= a;
        regWrData <= d;
        regWrStrobe <= 1'b1;
        @(posedge ref_clk);
        regWrStrobe <= 1'b0;
    endtask

    // Data is looked at only in the single cycle after the strobe
    // Bits cleared in care are not compared; exp must be zero there
    task automatic reg_read(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp,
                            input logic [DATA_W-1:0] care = 32'hffff_ffff);
        regAddr <= a;
        regRdStrobe <= 1'b1;
        @(posedge ref_clk);
        regRdStrobe <= 1'b0;
        @(negedge ref_clk);
        check_word(regRdData & care, exp);
        @(posedge ref_clk);
    endtask

    // Waits past the five-edge pin latency plus the model's own edge
    task automatic expect_phy();
        logic [NUM_PORTS-1:0] live;
        logic [NUM_PORTS-1:0] expA;
        logic [NUM_PORTS-1:0] expB;
        repeat (8) @(posedge ref_clk);
        // Expectation taken after the wait, so stimulus set just before the call is seen
        live = (legacy ? 3'h7 : connected) & maskExp;
        expA = live & ~flipped;
        expB = live & flipped;
        @(negedge ref_clk);
        check_vec(phyEnA, expA);
        check_vec(phyEnB, expB);
        check_vec(phyPwrEn, expA | expB);
        @(posedge ref_clk);
        reg_read(REG_STATUS_OFS, {21'h0, expA | expB, polSel, modeTwo, expB, expA});
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    // Reset values, unmapped read, write to a read-only place
    task automatic test_reset();
        expect_phy();
        reg_read(REG_CTRL_OFS, 32'h0000_0007);
        reg_read(8'h0c, 32'h0000_0000);
        reg_write(REG_STATUS_OFS, 32'h0000_0000);
        reg_read(REG_CTRL_OFS, 32'h0000_0007);
    endtask

    // Every polarity and mode against a table of attach and flip patterns
    task automatic test_decode();
        logic [NUM_PORTS-1:0] conTab [5] = '{3'h0, 3'h7, 3'h7, 3'h5, 3'h3};
        logic [NUM_PORTS-1:0] flipTab [5] = '{3'h0, 3'h0, 3'h7, 3'h2, 3'h6};
        for (int m = 0; m < 4; m++)
        begin
            for (int i = 0; i < 5; i++)
            begin
                polSel <= m[0];
                modeTwo <= m[1];
                connected <= conTab[i];
                flipped <= flipTab[i];
                expect_phy();
            end
        end
    endtask

    // Mask write read back with no gap, then its effect on the enables
    task automatic test_mask();
        polSel <= 1'b0;
        modeTwo <= 1'b0;
        connected <= 3'h7;
        flipped <= 3'h4;
        reg_write(REG_CTRL_OFS, 32'h0000_0005);
        reg_read(REG_CTRL_OFS, 32'h0000_0005);
        maskExp = 3'h5;
        expect_phy();
        reg_read(REG_INPUTS_OFS, 32'h0000_0027, 32'hffff_f03f);
    endtask

    // Legacy board ties attach high: all pairs powered
    task automatic test_legacy();
        reg_write(REG_CTRL_OFS, 32'h0000_0007);
        maskExp = 3'h7;
        legacy <= 1'b1;
        connected <= 3'h0;
        flipped <= 3'h2;
        expect_phy();
        legacy <= 1'b0;
    endtask

    // Reset in mid-run clears enables at once and restores the mask
    task automatic test_midreset();
        reg_write(REG_CTRL_OFS, 32'h0000_0003);
        connected <= 3'h7;
        nrst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
        check_vec(phyPwrEn, 3'h0);
        @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        maskExp = 3'h7;
        reg_read(REG_CTRL_OFS, 32'h0000_0007);
        expect_phy();
    endtask

    // Watchdog well beyond the roughly 300 cycles the tests need
    initial
    begin
        repeat (5000) @(posedge ref_clk);
        error_cnt++;
        test_done();
    end

    initial
    begin
        repeat (16) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        test_reset();
        test_decode();
        test_mask();
        test_legacy();
        test_midreset();
        test_done();
    end
endmodule // tb
